// ### design/ucs_pkg.sv
// Package: constants, register map and carrier types of the serial control/status block
package ucs_pkg;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] ADDR_LINE_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_TX_RX_CTRL  = 8'h04;
  localparam logic [7:0] ADDR_NINTH_ERR   = 8'h08;
  localparam logic [7:0] ADDR_LINE_STAT   = 8'h0c;
  localparam logic [7:0] ADDR_DATA_BUF    = 8'h10;

  // ==========================================================
  // Field positions
  localparam int LC_MODULE_ON = 0;
  localparam int LC_CHAR9     = 1;
  localparam int LC_WAKE_ADDR = 2;
  localparam int NE_RX_NINTH  = 7;
  localparam int NE_TX_NINTH  = 6;
  localparam int ST_TX_EMPTY  = 7;
  localparam int ST_TX_DONE   = 6;
  localparam int ST_RX_FULL   = 5;
  localparam int ST_QUIET     = 4;
  localparam int ST_OVERRUN   = 3;
  localparam int ST_NOISE     = 2;
  localparam int ST_FRAME     = 1;
  localparam int ST_PARITY    = 0;

  // ==========================================================
  // Reset values
  localparam logic [7:0] LINE_CTRL_RST  = 8'h00;
  localparam logic [7:0] TX_RX_CTRL_RST = 8'h00;
  localparam logic [3:0] ERR_EN_RST     = 4'h0;
  localparam logic [7:0] LINE_STAT_RST  = 8'hc0;

  // ==========================================================
  // Timing: 16x oversampling tick, 100 MHz clock
  localparam int          CLK_HZ     = 100_000_000;
  localparam int          BAUD_HZ    = 115_200;
  localparam logic [15:0] OVS_DIV    = 16'((CLK_HZ + 8 * BAUD_HZ) / (16 * BAUD_HZ));
  localparam logic [3:0]  OVS_LAST   = 4'hf;
  localparam logic [3:0]  OVS_MID    = 4'h8;
  localparam logic [3:0]  LEN8       = 4'ha;
  localparam logic [3:0]  LEN9       = 4'hb;

  // ==========================================================
  // Carrier types
  typedef struct packed {
    logic tx_empty_irq_en;
    logic tx_done_irq_en;
    logic rx_full_irq_en;
    logic quiet_line_irq_en;
    logic xmit_on;
    logic rx_on;
    logic rx_standby;
    logic break_send;
  } ucs_ctrl_type;

  typedef struct packed {
    logic       done;
    logic [8:0] data;
    logic       frame_err;
    logic       noise;
    logic       quiet;
  } ucs_rx_type;

endpackage : ucs_pkg

// ### design/ucs_baud.sv
// Oversampling tick divider
`timescale 1ns/1ps
module ucs_baud (
  input  wire logic I_CLK,
  input  wire logic I_RST,
  input  wire logic i_en,
  output logic      o_tick16,
  output logic      o_tick1
);
  import ucs_pkg::*;

  logic [15:0] div_r;
  logic [3:0]  sub_r;

  // ==========================================================
  // Divider, held at zero while the module is off
  always_ff @(posedge I_CLK) begin
    if (I_RST || !i_en) begin
      div_r    <= 16'h0000;
      sub_r    <= 4'h0;
      o_tick16 <= 1'b0;
      o_tick1  <= 1'b0;
    end else begin
      o_tick16 <= (div_r == OVS_DIV - 16'h0001);
      o_tick1  <= (div_r == OVS_DIV - 16'h0001) && (sub_r == OVS_LAST);
      if (div_r == OVS_DIV - 16'h0001) begin
        div_r <= 16'h0000;
        sub_r <= sub_r + 4'h1;
      end else begin
        div_r <= div_r + 16'h0001;
      end
    end
  end

endmodule : ucs_baud

// ### design/ucs_rx.sv
// Receiver: start search, majority sampling, quiet-line detection
`timescale 1ns/1ps
module ucs_rx (
  input  wire logic              I_CLK,
  input  wire logic              I_RST,
  input  wire logic              i_en,
  input  wire logic              i_tick16,
  input  wire logic              i_rxd,
  input  wire logic              i_char9,
  output ucs_pkg::ucs_rx_type    o_rx
);
  import ucs_pkg::*;

  logic        busy_r;
  logic [3:0]  sub_r;
  logic [3:0]  bitn_r;
  logic [10:0] sh_r;
  logic [2:0]  smp_r;
  logic        noisy_r;
  logic [7:0]  quiet_r;
  logic [3:0]  len;
  logic        maj;

  assign len = i_char9 ? LEN9 : LEN8;
  assign maj = (smp_r[0] & smp_r[1]) | (smp_r[0] & i_rxd) | (smp_r[1] & i_rxd);

  // ==========================================================
  // Frame reception; stops at once when disabled
  always_ff @(posedge I_CLK) begin
    if (I_RST || !i_en) begin
      busy_r  <= 1'b0;
      sub_r   <= 4'h0;
      bitn_r  <= 4'h0;
      sh_r    <= 11'h000;
      smp_r   <= 3'h0;
      noisy_r <= 1'b0;
      o_rx    <= '0;
    end else begin
      o_rx.done  <= 1'b0;
      o_rx.quiet <= 1'b0;
      // One pulse as the idle count reaches a full character time
      if (i_tick16 && !busy_r && i_rxd && quiet_r == {len, 4'h0} - 8'h01) o_rx.quiet <= 1'b1;
      if (i_tick16) begin
        if (!busy_r) begin
          if (!i_rxd) begin
            busy_r  <= 1'b1;
            sub_r   <= 4'h1;
            bitn_r  <= 4'h0;
            noisy_r <= 1'b0;
          end
        end else begin
          sub_r <= sub_r + 4'h1;
          if (sub_r == OVS_MID - 4'h2) smp_r[0] <= i_rxd;
          if (sub_r == OVS_MID - 4'h1) smp_r[1] <= i_rxd;
          if (sub_r == OVS_MID) begin
            if (smp_r[0] != smp_r[1] || smp_r[1] != i_rxd) noisy_r <= 1'b1;
            if (bitn_r == 4'h0 && maj) begin
              busy_r <= 1'b0;
            end else begin
              sh_r   <= {maj, sh_r[10:1]};
              bitn_r <= bitn_r + 4'h1;
              if (bitn_r == len - 4'h1) begin
                busy_r         <= 1'b0;
                o_rx.done      <= 1'b1;
                o_rx.frame_err <= !maj;
                o_rx.noise     <= noisy_r || (smp_r[0] != smp_r[1]) || (smp_r[1] != i_rxd);
                o_rx.data      <= i_char9 ? sh_r[10:2] : {1'b0, sh_r[10:3]};
              end
            end
          end
        end
      end
    end
  end

  // ==========================================================
  // Quiet line: one full character time of high input
  always_ff @(posedge I_CLK) begin
    if (I_RST || !i_en) begin
      quiet_r <= 8'h00;
    end else if (i_tick16) begin
      if (busy_r || !i_rxd) begin
        quiet_r <= 8'h00;
      end else if (quiet_r != {len, 4'h0}) begin
        quiet_r <= quiet_r + 8'h01;
      end
    end
  end

endmodule : ucs_rx

// ### design/ucs_top.sv
// Serial control/status block: APB registers, transmitter and interrupt requests
`timescale 1ns/1ps
module ucs_top (
  input  wire logic        I_CLK,
  input  wire logic        I_RST,
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [7:0]  I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  input  wire logic        I_RXD,
  output logic             O_TXD,
  input  wire logic        I_PARITY_ERR,
  output logic             O_TX_IRQ,
  output logic             O_RX_IRQ,
  output logic             O_ERR_IRQ
);
  import ucs_pkg::*;

  // ==========================================================
  // Declarations
  logic [7:0]   line_ctrl_r;
  ucs_ctrl_type ctl_r;
  logic [3:0]   err_en_r;
  logic         tx_ninth_r;
  logic         rx_ninth_r;
  logic [7:0]   stat_r;
  logic [7:0]   arm_r;
  logic [7:0]   tx_buf_r;
  logic [7:0]   rx_buf_r;
  logic         quiet_allow_r;
  logic         rxd_s1_r;
  logic         rxd_s2_r;
  logic         xmit_prev_r;
  logic         pend_pre_r;
  logic         brk_tail_r;
  logic         brk_pend_r;
  logic [10:0]  tx_sh_r;
  logic [3:0]   tx_cnt_r;
  logic         txd_r;
  logic [31:0]  rdata_nxt;
  logic         tick16;
  logic         tick1;
  ucs_rx_type   rx;
  logic         module_on;
  logic         char9;
  logic [3:0]   len;
  logic         wr_done;
  logic         rd_done;
  logic         mapped;
  logic         ld_data;
  logic         ld_pre;
  logic         ld_brk;
  logic         ld_tail;
  logic         rx_load;
  logic         rx_msb;
  logic         wake;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] reg_addr);
    hit = (addr == reg_addr);
  endfunction : hit

  assign module_on = line_ctrl_r[LC_MODULE_ON];
  assign char9     = line_ctrl_r[LC_CHAR9];
  assign len       = char9 ? LEN9 : LEN8;
  assign mapped    = hit(I_PADDR, ADDR_LINE_CTRL) || hit(I_PADDR, ADDR_TX_RX_CTRL) ||
                     hit(I_PADDR, ADDR_NINTH_ERR) || hit(I_PADDR, ADDR_LINE_STAT) ||
                     hit(I_PADDR, ADDR_DATA_BUF);
  assign wr_done   = I_PSEL && I_PENABLE && I_PWRITE && mapped;
  assign rd_done   = I_PSEL && I_PENABLE && !I_PWRITE && mapped;

  // ==========================================================
  // Bus answer: zero wait states, error on unmapped addresses
  assign O_PREADY  = 1'b1;
  assign O_PSLVERR = I_PSEL && I_PENABLE && !mapped;

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (hit(I_PADDR, ADDR_LINE_CTRL)) rdata_nxt[7:0] = line_ctrl_r;
    if (hit(I_PADDR, ADDR_TX_RX_CTRL)) rdata_nxt[7:0] = ctl_r;
    if (hit(I_PADDR, ADDR_NINTH_ERR)) rdata_nxt[7:0] = {rx_ninth_r, tx_ninth_r, 2'b00, err_en_r};
    if (hit(I_PADDR, ADDR_LINE_STAT)) rdata_nxt[7:0] = stat_r;
    if (hit(I_PADDR, ADDR_DATA_BUF)) rdata_nxt[7:0] = rx_buf_r;
  end

  // Read data is captured in the setup cycle so it leaves a flip-flop
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_PRDATA <= 32'h0000_0000;
    end else if (I_PSEL && !I_PENABLE) begin
      O_PRDATA <= rdata_nxt;
    end
  end

  // ==========================================================
  // Control registers
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      line_ctrl_r <= LINE_CTRL_RST;
      ctl_r       <= TX_RX_CTRL_RST;
      err_en_r    <= ERR_EN_RST;
      tx_ninth_r  <= 1'b0;
    end else begin
      if (wr_done && hit(I_PADDR, ADDR_LINE_CTRL)) line_ctrl_r <= {5'h00, I_PWDATA[2:0]};
      if (wr_done && hit(I_PADDR, ADDR_TX_RX_CTRL)) begin
        ctl_r.tx_empty_irq_en   <= I_PWDATA[7];
        ctl_r.tx_done_irq_en    <= I_PWDATA[6];
        ctl_r.rx_full_irq_en    <= I_PWDATA[5];
        ctl_r.quiet_line_irq_en <= I_PWDATA[4];
        ctl_r.break_send        <= I_PWDATA[0];
        // Transmitter and receiver enables are frozen while the module is off, so a stray write does no harm
        if (module_on) begin
          ctl_r.xmit_on <= I_PWDATA[3];
          ctl_r.rx_on   <= I_PWDATA[2];
        end
        ctl_r.rx_standby <= I_PWDATA[1] | (ctl_r.rx_standby & wake);
      end
      if (wake) ctl_r.rx_standby <= 1'b0;
      if (wr_done && hit(I_PADDR, ADDR_NINTH_ERR)) begin
        tx_ninth_r <= I_PWDATA[NE_TX_NINTH];
        err_en_r   <= I_PWDATA[3:0];
      end
    end
  end

  // ==========================================================
  // Receive line synchroniser
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      rxd_s1_r <= 1'b1;
      rxd_s2_r <= 1'b1;
    end else begin
      rxd_s1_r <= I_RXD;
      rxd_s2_r <= rxd_s1_r;
    end
  end

  ucs_baud u_baud (
    .I_CLK    (I_CLK),
    .I_RST    (I_RST),
    .i_en     (module_on),
    .o_tick16 (tick16),
    .o_tick1  (tick1)
  );

  ucs_rx u_rx (
    .I_CLK    (I_CLK),
    .I_RST    (I_RST),
    .i_en     (module_on && ctl_r.rx_on),
    .i_tick16 (tick16),
    .i_rxd    (rxd_s2_r),
    .i_char9  (char9),
    .o_rx     (rx)
  );

  // ==========================================================
  // Receive path and wake-up
  assign rx_msb  = char9 ? rx.data[8] : rx.data[7];
  assign wake    = ctl_r.rx_standby &&
                   (line_ctrl_r[LC_WAKE_ADDR] ? (rx.done && rx_msb) : rx.quiet);
  // Characters heard in standby are dropped unless they carry the wake mark
  assign rx_load = rx.done && !stat_r[ST_RX_FULL] && (!ctl_r.rx_standby || wake);

  always_ff @(posedge I_CLK) begin
    if (rx_load) begin
      rx_buf_r   <= rx.data[7:0];
      rx_ninth_r <= rx_msb;
    end
  end

  // ==========================================================
  // Transmit selection: break first, then break tail, preamble, data
  always_comb begin
    ld_brk  = 1'b0;
    ld_tail = 1'b0;
    ld_pre  = 1'b0;
    ld_data = 1'b0;
    if (module_on && tick1 && tx_cnt_r == 4'h0) begin
      if ((ctl_r.break_send || brk_pend_r) && ctl_r.xmit_on) begin
        ld_brk = 1'b1;
      end else if (brk_tail_r) begin
        ld_tail = 1'b1;
      end else if (pend_pre_r && ctl_r.xmit_on) begin
        ld_pre = 1'b1;
      end else if (ctl_r.xmit_on && !stat_r[ST_TX_EMPTY]) begin
        ld_data = 1'b1;
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST || !module_on) begin
      xmit_prev_r <= 1'b0;
      pend_pre_r  <= 1'b0;
      brk_tail_r  <= 1'b0;
      brk_pend_r  <= 1'b0;
      tx_sh_r     <= 11'h7ff;
      tx_cnt_r    <= 4'h0;
      txd_r       <= 1'b1;
    end else begin
      xmit_prev_r <= ctl_r.xmit_on;
      // A re-enable while busy simply queues another all-ones character
      if (ctl_r.xmit_on && !xmit_prev_r) pend_pre_r <= 1'b1;
      if (ld_pre || ld_brk) pend_pre_r <= 1'b0;
      if (ld_brk) brk_tail_r <= 1'b1;
      if (ld_tail) brk_tail_r <= 1'b0;
      // A set-then-clear shorter than a bit time must still send its break
      if (ctl_r.break_send && ctl_r.xmit_on && !brk_tail_r) brk_pend_r <= 1'b1;
      if (ld_brk) brk_pend_r <= 1'b0;
      if (tick1) begin
        if (ld_brk) begin
          txd_r    <= 1'b0;
          tx_sh_r  <= 11'h000;
          tx_cnt_r <= len - 4'h1;
        end else if (ld_tail) begin
          txd_r    <= 1'b1;
          tx_cnt_r <= 4'h0;
        end else if (ld_pre) begin
          txd_r    <= 1'b1;
          tx_sh_r  <= 11'h7ff;
          tx_cnt_r <= len - 4'h1;
        end else if (ld_data) begin
          txd_r    <= 1'b0;
          tx_sh_r  <= char9 ? {1'b1, 1'b1, tx_ninth_r, tx_buf_r} : {1'b1, 1'b1, 1'b1, tx_buf_r};
          tx_cnt_r <= len - 4'h1;
        end else if (tx_cnt_r != 4'h0) begin
          txd_r    <= tx_sh_r[0];
          tx_sh_r  <= {1'b1, tx_sh_r[10:1]};
          tx_cnt_r <= tx_cnt_r - 4'h1;
        end else begin
          txd_r <= 1'b1;
        end
      end
    end
  end

  assign O_TXD = txd_r;

  always_ff @(posedge I_CLK) begin
    if (wr_done && hit(I_PADDR, ADDR_DATA_BUF)) tx_buf_r <= I_PWDATA[7:0];
  end

  // ==========================================================
  // Status flags; a hardware set beats a same-cycle clear
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      stat_r        <= LINE_STAT_RST;
      arm_r         <= 8'h00;
      quiet_allow_r <= 1'b0;
    end else begin
      if (rd_done && hit(I_PADDR, ADDR_LINE_STAT)) arm_r <= stat_r;
      if (wr_done && hit(I_PADDR, ADDR_DATA_BUF) && arm_r[ST_TX_EMPTY]) begin
        stat_r[ST_TX_EMPTY] <= 1'b0;
        arm_r[ST_TX_EMPTY]  <= 1'b0;
      end
      if (rd_done && hit(I_PADDR, ADDR_DATA_BUF)) begin
        stat_r[5:1] <= stat_r[5:1] & ~arm_r[5:1];
        arm_r[5:1]  <= 5'h00;
      end
      if (ld_data) stat_r[ST_TX_EMPTY] <= 1'b1;
      // Done only when nothing is loaded or queued; queueing drops it next cycle
      stat_r[ST_TX_DONE] <= stat_r[ST_TX_EMPTY] && tx_cnt_r == 4'h0 && !pend_pre_r &&
                            !brk_tail_r && !brk_pend_r && !(ctl_r.break_send && ctl_r.xmit_on);
      if (rx_load) begin
        stat_r[ST_RX_FULL] <= 1'b1;
        stat_r[ST_FRAME]   <= rx.frame_err;
        stat_r[ST_NOISE]   <= rx.noise;
        quiet_allow_r      <= 1'b1;
      end
      if (rx.done && stat_r[ST_RX_FULL]) stat_r[ST_OVERRUN] <= 1'b1;
      if (rx.quiet && quiet_allow_r) begin
        stat_r[ST_QUIET] <= 1'b1;
        quiet_allow_r    <= 1'b0;
      end
      if (I_PARITY_ERR) stat_r[ST_PARITY] <= 1'b1;
      if (rd_done && hit(I_PADDR, ADDR_DATA_BUF) && arm_r[ST_PARITY] && !I_PARITY_ERR) begin
        stat_r[ST_PARITY] <= 1'b0;
      end
      if (!module_on) begin
        stat_r[ST_TX_EMPTY] <= 1'b1;
        stat_r[ST_TX_DONE]  <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Interrupt requests, one output per source group
  assign O_TX_IRQ  = module_on && ((stat_r[ST_TX_EMPTY] && ctl_r.tx_empty_irq_en) ||
                                   (stat_r[ST_TX_DONE] && ctl_r.tx_done_irq_en));
  assign O_RX_IRQ  = !ctl_r.rx_standby &&
                     ((stat_r[ST_RX_FULL] && ctl_r.rx_full_irq_en) ||
                      (stat_r[ST_QUIET] && ctl_r.quiet_line_irq_en));
  assign O_ERR_IRQ = |(stat_r[3:0] & err_en_r);

endmodule : ucs_top

// ### verif/ucs_properties.sv
// Checker: port-level properties of the serial control/status block
`timescale 1ns/1ps
module ucs_props (
  input wire logic        I_CLK,
  input wire logic        I_RST,
  input wire logic        I_PSEL,
  input wire logic        I_PENABLE,
  input wire logic        I_PWRITE,
  input wire logic [7:0]  I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [31:0] O_PRDATA,
  input wire logic        O_PREADY,
  input wire logic        O_PSLVERR,
  input wire logic        I_RXD,
  input wire logic        O_TXD,
  input wire logic        I_PARITY_ERR,
  input wire logic        O_TX_IRQ,
  input wire logic        O_RX_IRQ,
  input wire logic        O_ERR_IRQ
);
  import ucs_pkg::*;
  // ==========================================================
  // Shadow of software writes; hardware-cleared bits are not used
  localparam int BT = 16 * int'(OVS_DIV);
  logic       wr;
  logic       wctl;
  logic [7:0] ctl_r;
  logic [7:0] err_r;
  logic       mod_r;
  logic       dw_r;
  logic       tx_r;
  int         cnt_r;
  assign wr   = I_PSEL & I_PENABLE & I_PWRITE & O_PREADY;
  assign wctl = wr && I_PADDR == ADDR_TX_RX_CTRL;
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      ctl_r <= 8'h00;
      err_r <= 8'h00;
      mod_r <= 1'b0;
      dw_r  <= 1'b0;
      tx_r  <= 1'b0;
    end else if (wr) begin
      if (wctl) ctl_r <= mod_r ? I_PWDATA[7:0] : {I_PWDATA[7:4], ctl_r[3:2], I_PWDATA[1:0]};
      if (I_PADDR == ADDR_NINTH_ERR) err_r <= I_PWDATA[7:0];
      if (I_PADDR == ADDR_LINE_CTRL) mod_r <= I_PWDATA[0];
      if (I_PADDR == ADDR_DATA_BUF) dw_r <= 1'b1;
      if (wctl && ((mod_r && I_PWDATA[3]) || I_PWDATA[0])) tx_r <= 1'b1;
    end
  end
  // ==========================================================
  // Preamble window: only the first enable is tracked, later ones may trail a character
  always_ff @(posedge I_CLK) begin
    if (I_RST) cnt_r <= 0;
    else if (wctl && mod_r && !tx_r && I_PWDATA[3] && !I_PWDATA[0]) cnt_r <= 10 * BT;
    else if (wctl) cnt_r <= 0;
    else if (cnt_r != 0) cnt_r <= cnt_r - 1;
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  property p_rst; $fell(I_RST) |-> O_TXD && !O_TX_IRQ && !O_RX_IRQ && !O_ERR_IRQ; endproperty
  a_rst: assert property (p_rst) else $error("Outputs not idle after reset");
  property p_empty; mod_r && !dw_r && ctl_r[7] |-> O_TX_IRQ; endproperty
  a_empty: assert property (p_empty) else $error("Empty request missing");
  property p_done; mod_r && !dw_r && !tx_r && ctl_r[6] |-> O_TX_IRQ; endproperty
  a_done: assert property (p_done) else $error("Done request missing");
  property p_rxmask; !ctl_r[5] && !ctl_r[4] |-> !O_RX_IRQ; endproperty
  a_rxmask: assert property (p_rxmask) else $error("Receiver request while masked");
  property p_errmask; err_r[3:0] == 4'h0 |-> !O_ERR_IRQ; endproperty
  a_errmask: assert property (p_errmask) else $error("Error request while masked");
  property p_parity; I_PARITY_ERR && err_r[0] |-> ##[1:2] O_ERR_IRQ; endproperty
  a_parity: assert property (p_parity) else $error("Parity request missing");
  property p_off; !mod_r |-> !O_TX_IRQ; endproperty
  a_off: assert property (p_off) else $error("Transmit request while module off");
  property p_pre; cnt_r != 0 |-> O_TXD; endproperty
  a_pre: assert property (p_pre) else $error("Line low during preamble");
  c_parity: cover property (I_PARITY_ERR && err_r[0]);
  c_pre: cover property (cnt_r == 1);
  c_rx: cover property (O_RX_IRQ);
endmodule : ucs_props

bind ucs_top ucs_props u_props (.I_CLK(I_CLK), .I_RST(I_RST), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
  .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
  .O_PSLVERR(O_PSLVERR), .I_RXD(I_RXD), .O_TXD(O_TXD), .I_PARITY_ERR(I_PARITY_ERR), .O_TX_IRQ(O_TX_IRQ),
  .O_RX_IRQ(O_RX_IRQ), .O_ERR_IRQ(O_ERR_IRQ));

// ### verif/ucs_node.sv
// Remote serial node: sends frames on the receive line, decodes the transmit line
`timescale 1ns/1ps
module ucs_node (
  input  wire logic I_CLK,
  input  wire logic i_txd,
  input  wire logic i_char9,
  output logic      o_rxd
);
  import ucs_pkg::*;
  localparam int BT = 16 * int'(OVS_DIV);
  logic [9:0] got_q[$];
  logic [9:0] f;
  // Idle line rests high, as a pulled-up line would
  initial o_rxd = 1'b1;
  // ==========================================================
  // Sender: 8-bit frames get a trailing idle bit so both lengths take 11 bits
  task automatic send(input logic [8:0] v);
    logic [10:0] fr;
    // Length is read after an edge so a change made just before the call applies
    @(posedge I_CLK);
    fr = i_char9 ? {1'b1, v, 1'b0} : {2'b11, v[7:0], 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge I_CLK);
      o_rxd <= fr[i];
      repeat (BT - 1) @(posedge I_CLK);
    end
  endtask : send
  // ==========================================================
  // Decoder: stop bit lands in bit 9 so breaks show as a low stop
  initial forever begin
    @(negedge i_txd);
    repeat (BT / 2) @(posedge I_CLK);
    if (i_txd === 1'b0) begin
      f = 10'h000;
      for (int i = 0; i <= (i_char9 ? 9 : 8); i++) begin
        repeat (BT) @(posedge I_CLK);
        if (i == (i_char9 ? 9 : 8)) f[9] = i_txd;
        else f[i] = i_txd;
      end
      got_q.push_back(f);
    end
  end
endmodule : ucs_node

// ### verif/test_uart_control_status.sv
// Testbench: registers, interrupts and serial traffic of the control/status block
`timescale 1ns/1ps
module test_uart_control_status;
  import ucs_pkg::*;
  localparam int BT = 16 * int'(OVS_DIV);
  logic        clk, rst, psel, pen, pwr, perr, txd, rxd, c9, rdy, serr, tirq, rirq, eirq, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [9:0]  exp_q[$];
  logic [8:0]  v;
  int          bad_count, checks;
  ucs_top dut (.I_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(rdy), .O_PSLVERR(serr), .I_RXD(rxd), .O_TXD(txd),
    .I_PARITY_ERR(perr), .O_TX_IRQ(tirq), .O_RX_IRQ(rirq), .O_ERR_IRQ(eirq));
  ucs_node node (.I_CLK(clk), .i_txd(txd), .i_char9(c9), .o_rxd(rxd));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========================================================
  // Tasks
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error at %0t: word %h, expected %h", $time, g, e);
    end
  endtask : chk_word
  task automatic chk_pin(input logic g, input logic e);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error at %0t: pin %b, expected %b", $time, g, e);
    end
  endtask : chk_pin
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (rdy !== 1'b1);
    rd = prdata;
    er = serr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk_word(rd, e);
  endtask : rdchk
  task automatic wait_irq(input logic rx);
    int n;
    n = 0;
    while (((rx ? rirq : tirq) !== 1'b1) && n < 12 * BT) begin
      @(posedge clk);
      n++;
    end
    chk_pin(rx ? rirq : tirq, 1'b1);
  endtask : wait_irq
  task automatic wait_frame();
    int n;
    n = 0;
    while (node.got_q.size() == 0 && n < 30 * BT) begin
      @(posedge clk);
      n++;
    end
    rd = 32'hxxxxxxxx;
    if (node.got_q.size() > 0) rd = {22'h0, node.got_q.pop_front()};
    chk_word(rd, {22'h0, exp_q.pop_front()});
  endtask : wait_frame
  // ==========================================================
  // Watchdog: the run needs about 80 bit times
  initial begin
    repeat (95000) @(posedge clk);
    bad_count++;
    close_out();
  end
  // ==========================================================
  // Main sequence
  initial begin
    {rst, psel, pen, pwr, perr, c9} = 6'b100001;
    paddr = 8'h00;
    pwdata = 32'h0;
    bad_count = 0;
    checks = 0;
    v = 9'($urandom(32'h7f88e726));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rdchk(ADDR_TX_RX_CTRL, 32'h00);
    rdchk(ADDR_LINE_STAT, 32'hc0);
    apb(1'b0, ADDR_NINTH_ERR, 32'h0);
    chk_word(rd & 32'h4f, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk_pin(er, 1'b1);
    apb(1'b1, ADDR_TX_RX_CTRL, 32'h0c);
    rdchk(ADDR_TX_RX_CTRL, 32'h00);
    apb(1'b1, ADDR_LINE_CTRL, 32'h03);
    for (int i = 6; i < 8; i++) begin
      apb(1'b1, ADDR_TX_RX_CTRL, 32'h1 << i);
      @(negedge clk);
      chk_pin(tirq, 1'b1);
    end
    apb(1'b1, ADDR_LINE_CTRL, 32'h00);
    @(negedge clk);
    chk_pin(tirq, 1'b0);
    apb(1'b1, ADDR_TX_RX_CTRL, 32'h00);
    apb(1'b1, ADDR_LINE_CTRL, 32'h03);
    repeat (4) begin
      v = 9'($urandom);
      apb(1'b1, ADDR_NINTH_ERR, {23'h0, v});
      apb(1'b0, ADDR_NINTH_ERR, 32'h0);
      chk_word(rd & 32'h4f, {23'h0, v} & 32'h4f);
    end
    apb(1'b1, ADDR_NINTH_ERR, 32'h41);
    @(posedge clk) perr <= 1'b1;
    @(posedge clk) perr <= 1'b0;
    @(negedge clk);
    chk_pin(eirq, 1'b1);
    rdchk(ADDR_LINE_STAT, 32'hc1);
    apb(1'b0, ADDR_DATA_BUF, 32'h0);
    @(negedge clk);
    chk_pin(eirq, 1'b0);
    // Transmit: data waits behind the preamble, ninth bit rides along
    apb(1'b1, ADDR_TX_RX_CTRL, 32'h08);
    v = 9'($urandom);
    apb(1'b0, ADDR_LINE_STAT, 32'h0);
    apb(1'b1, ADDR_DATA_BUF, {24'h0, v[7:0]});
    exp_q.push_back({2'b11, v[7:0]});
    rdchk(ADDR_LINE_STAT, 32'h00);
    wait_frame();
    apb(1'b1, ADDR_TX_RX_CTRL, 32'h48);
    wait_irq(1'b0);
    rdchk(ADDR_LINE_STAT, 32'hc0);
    apb(1'b1, ADDR_TX_RX_CTRL, 32'h09);
    apb(1'b1, ADDR_TX_RX_CTRL, 32'h08);
    exp_q.push_back(10'h000);
    rdchk(ADDR_LINE_STAT, 32'h80);
    wait_frame();
    // Receive in both lengths, then with the receiver off
    apb(1'b1, ADDR_TX_RX_CTRL, 32'h24);
    for (int m = 1; m >= 0; m--) begin
      apb(1'b1, ADDR_LINE_CTRL, 32'(1 + 2 * m));
      c9 <= m[0];
      v = 9'($urandom);
      node.send(v);
      wait_irq(1'b1);
      apb(1'b0, ADDR_LINE_STAT, 32'h0);
      chk_pin(rd[ST_RX_FULL], 1'b1);
      rdchk(ADDR_DATA_BUF, {24'h0, v[7:0]});
      apb(1'b0, ADDR_NINTH_ERR, 32'h0);
      chk_pin(rd[NE_RX_NINTH], m[0] ? v[8] : v[7]);
      @(negedge clk);
      chk_pin(rirq, 1'b0);
    end
    // Quiet line after the last character raises the receiver request
    apb(1'b1, ADDR_TX_RX_CTRL, 32'h34);
    wait_irq(1'b1);
    apb(1'b0, ADDR_LINE_STAT, 32'h0);
    chk_pin(rd[ST_QUIET], 1'b1);
    apb(1'b1, ADDR_TX_RX_CTRL, 32'h20);
    node.send(9'h0a5);
    apb(1'b0, ADDR_LINE_STAT, 32'h0);
    chk_pin(rd[ST_RX_FULL], 1'b0);
    close_out();
  end
endmodule : test_uart_control_status
